/* hdl/updown_timer_pkg.sv */
// Purpose: Shared constants for the up/down reload timer and its prescaler.
// Assumes: APB register access, one 250 MHz clock, synchronous active-high reset.
// Notes:   Register indices are word indices; the byte address is four times the index.
package updown_timer_pkg;

  localparam int          ADDR_W          = 18;
  localparam int          DATA_W          = 32;
  localparam int          IDX_W           = 16;
  localparam int          CNT_W           = 8;
  localparam int          NUM_TAPS        = 7;
  localparam int          PRE_W           = 13;

  // Register word indices.
  localparam logic [15:0] MODE_IDX        = 16'hFFC4;
  localparam logic [15:0] COUNT_IDX       = 16'hFFC5;
  localparam logic [15:0] IRQ_REQ_IDX     = 16'hFFF0;
  localparam logic [15:0] IRQ_EN_IDX      = 16'hFFF1;
  localparam logic [15:0] EDGE_SEL_IDX    = 16'hFFF2;

  // Mode register layout and reset value.
  localparam int          RELOAD_BIT      = 7;
  localparam int          DIR_SRC_BIT     = 6;
  localparam int          SOFT_DIR_BIT    = 5;
  localparam int          CLK_SEL_HI      = 2;
  localparam int          CLK_SEL_LO      = 0;
  localparam logic [7:0]  MODE_RESET      = 8'h18;
  localparam logic [7:0]  MODE_RSVD_ONES  = 8'h18;
  localparam logic [7:0]  MODE_WR_MASK    = 8'hE7;

  // Single-bit fields of the request, enable and edge registers.
  localparam int          FLAG_BIT        = 0;
  localparam int          EDGE_BIT        = 0;

  localparam logic [7:0]  CNT_RESET       = 8'h00;
  localparam logic [7:0]  CNT_MAX         = 8'hFF;
  localparam logic [7:0]  CNT_MIN         = 8'h00;
  localparam logic [2:0]  CLK_SEL_EXT     = 3'h7;

  // Log2 of each prescaler tap divisor, in clock-select order: 8192 down to 8.
  localparam int          TAP_LOG [NUM_TAPS] = '{13, 11, 9, 8, 7, 5, 3};

endpackage

/* hdl/timer_prescaler.sv */
// Purpose: Free-running prescaler producing one-cycle enables at each tap rate.
// Assumes: Single clock; taps are powers of two no wider than the counter.
// Notes:   Each tap pulse is registered so it lines up with the cycle in which the count wraps.
`timescale 1ns/10ps
`default_nettype none
module timer_prescaler
#(
  parameter int PRE_WIDTH = updown_timer_pkg::PRE_W
) (
  input  wire logic                                ref_clk,
  input  wire logic                                srst,
  output logic [updown_timer_pkg::NUM_TAPS-1:0]    tap_pulse
);
  import updown_timer_pkg::*;

  logic [PRE_WIDTH-1:0] div_reg;
  logic [NUM_TAPS-1:0]  tap_hit;

  genvar g;
  generate
    for (g = 0; g < NUM_TAPS; g = g + 1) begin : g_tap
      assign tap_hit[g] = &div_reg[TAP_LOG[g]-1:0];
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_reg   <= '0;
      tap_pulse <= '0;
    end else begin
      div_reg   <= div_reg + 1'b1;
      tap_pulse <= tap_hit;
    end
  end

endmodule
`default_nettype wire

/* hdl/updown_reload_timer.sv */
// Purpose: 8-bit up/down timer with interval and auto-reload modes behind an APB slave.
// Assumes: Event and direction pins are synchronous inputs, resynchronised here anyway.
// Notes:   Each APB access takes one wait state; unmapped addresses answer with pslverr.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Reload mode bit: 0 gives interval timing, 1 gives auto-reload.
// - With software direction, soft bit 0 counts up, 1 counts down.
// - With hardware direction, pin high counts down, pin low counts up.
// - Mode bits 4 and 3 always read 1 and ignore writes.
// - Mode register resets to 0x18.
// - Clock select picks one of seven prescaler taps or the event pin.
// - Event pin active edge comes from the edge polarity bit.
// - Counter is 8 bits, read-only, readable any time without disturbing it.
// - Overflow past 0xFF or underflow past 0x00 sets the request flag.
// - Interrupt goes out when request flag and its enable are both set.
// - Interval mode wraps to 0x00 on overflow, 0xFF on underflow.
// - Writing the reload value also loads the counter at once.
// - Auto-reload mode loads the reload value on each overflow or underflow.
// - Counter reads and reload writes share one address.
// - Counter and reload value clear to 0x00 on reset.
// - Counting up starts straight after reset without software help.
// - Counter moves by exactly one per selected count pulse, unless it wraps in auto-reload mode or a reload write lands in the same cycle.
module updown_reload_timer
(
  input  wire logic                               ref_clk,
  input  wire logic                               srst,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [updown_timer_pkg::ADDR_W-1:0] paddr,
  input  wire logic [updown_timer_pkg::DATA_W-1:0] pwdata,
  output logic      [updown_timer_pkg::DATA_W-1:0] prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic                               event_input_pin,
  input  wire logic                               direction_pin,
  output logic                                    irq_out
);
  import updown_timer_pkg::*;

  logic [7:0]          timer_mode_ctrl_reg;
  logic [7:0]          timer_count_value_reg;
  logic [7:0]          timer_reload_value_reg;
  logic                overflow_request_flag_reg;
  logic                overflow_irq_enable_reg;
  logic                event_edge_polarity_reg;
  logic [2:0]          ev_sync_reg;
  logic [1:0]          dir_sync_reg;
  logic [NUM_TAPS-1:0] tap_pulse;

  // Bus decode.
  wire [IDX_W-1:0] word_idx     = paddr[ADDR_W-1:2];
  wire             hit_mode     = (word_idx == MODE_IDX);
  wire             hit_count    = (word_idx == COUNT_IDX);
  wire             hit_req      = (word_idx == IRQ_REQ_IDX);
  wire             hit_en       = (word_idx == IRQ_EN_IDX);
  wire             hit_edge     = (word_idx == EDGE_SEL_IDX);
  wire             hit_any      = hit_mode | hit_count | hit_req | hit_en | hit_edge;
  wire             access_done  = psel & penable & pready;
  wire             wr_done      = access_done & pwrite & hit_any;
  wire             wr_mode      = wr_done & hit_mode;
  wire             wr_reload    = wr_done & hit_count;
  wire             wr_req       = wr_done & hit_req;
  wire             wr_en        = wr_done & hit_en;
  wire             wr_edge      = wr_done & hit_edge;
  wire [7:0]       wbyte        = pwdata[7:0];

  // Mode fields.
  wire             reload_mode_select      = timer_mode_ctrl_reg[RELOAD_BIT];
  wire             direction_source_select = timer_mode_ctrl_reg[DIR_SRC_BIT];
  wire             soft_direction          = timer_mode_ctrl_reg[SOFT_DIR_BIT];
  wire [2:0]       clock_select            = timer_mode_ctrl_reg[CLK_SEL_HI:CLK_SEL_LO];

  // Pin conditioning: ev_sync_reg[0] and dir_sync_reg[0] are the metastable stages.
  wire             ev_now       = ev_sync_reg[1];
  wire             ev_prev      = ev_sync_reg[2];
  wire             dir_pin_s    = dir_sync_reg[1];
  wire             ev_rise      = ev_now & ~ev_prev;
  wire             ev_fall      = ~ev_now & ev_prev;
  wire             ev_edge      = event_edge_polarity_reg ? ev_rise : ev_fall;

  // Count enable and direction.
  wire             ext_sel      = (clock_select == CLK_SEL_EXT);
  wire             tap_tick     = ext_sel ? 1'b0 : tap_pulse[clock_select];
  wire             count_tick   = ext_sel ? ev_edge : tap_tick;
  wire             count_down   = direction_source_select ? dir_pin_s
                                                          : soft_direction;
  wire             at_max       = (timer_count_value_reg == CNT_MAX);
  wire             at_min       = (timer_count_value_reg == CNT_MIN);
  wire             wrap_event   = count_tick & (count_down ? at_min : at_max);
  wire [7:0]       stepped      = count_down ? timer_count_value_reg - 8'h01
                                             : timer_count_value_reg + 8'h01;
  wire [7:0]       wrap_value   = count_down ? CNT_MAX : CNT_MIN;

  logic [7:0] count_next;
  always_comb begin
    count_next = timer_count_value_reg;
    if (wr_reload) begin
      count_next = wbyte;
    end else if (wrap_event) begin
      count_next = reload_mode_select ? timer_reload_value_reg
                                      : wrap_value;
    end else if (count_tick) begin
      count_next = stepped;
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  wire flag_next = wrap_event | (overflow_request_flag_reg & ~(wr_req & ~wbyte[FLAG_BIT]));

  // Read mux; the counter read has no side effect on counting.
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_mode) begin
      rd_byte = timer_mode_ctrl_reg | MODE_RSVD_ONES;
    end else if (hit_count) begin
      rd_byte = timer_count_value_reg;
    end else if (hit_req) begin
      rd_byte[FLAG_BIT] = overflow_request_flag_reg;
    end else if (hit_en) begin
      rd_byte[FLAG_BIT] = overflow_irq_enable_reg;
    end else if (hit_edge) begin
      rd_byte[EDGE_BIT] = event_edge_polarity_reg;
    end
  end

  timer_prescaler #(
    .PRE_WIDTH (PRE_W)
  ) u_prescaler (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .tap_pulse (tap_pulse)
  );

  // APB answer: one wait state, response data registered with pready.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit_any;
      if (psel & penable & ~pready) begin
        prdata <= (pwrite | ~hit_any) ? '0 : {{(DATA_W-8){1'b0}}, rd_byte};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timer_mode_ctrl_reg <= MODE_RESET;
    end else if (wr_mode) begin
      timer_mode_ctrl_reg <= (wbyte & MODE_WR_MASK) | MODE_RSVD_ONES;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timer_count_value_reg  <= CNT_RESET;
      timer_reload_value_reg <= CNT_RESET;
    end else begin
      timer_count_value_reg <= count_next;
      if (wr_reload) begin
        timer_reload_value_reg <= wbyte;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      overflow_request_flag_reg <= 1'b0;
      overflow_irq_enable_reg   <= 1'b0;
      event_edge_polarity_reg   <= 1'b0;
      irq_out                   <= 1'b0;
    end else begin
      overflow_request_flag_reg <= flag_next;
      if (wr_en) begin
        overflow_irq_enable_reg <= wbyte[FLAG_BIT];
      end
      if (wr_edge) begin
        event_edge_polarity_reg <= wbyte[EDGE_BIT];
      end
      irq_out <= overflow_request_flag_reg & overflow_irq_enable_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ev_sync_reg  <= '0;
      dir_sync_reg <= '0;
    end else begin
      ev_sync_reg  <= {ev_sync_reg[1:0], event_input_pin};
      dir_sync_reg <= {dir_sync_reg[0], direction_pin};
    end
  end

  // Checks.
  sequence s_reload_write;
    psel && penable && pready && pwrite && hit_count;
  endsequence

  sequence s_plain_up;
    count_tick && !count_down && !at_max && !wr_reload;
  endsequence

  sequence s_plain_down;
    count_tick && count_down && !at_min && !wr_reload;
  endsequence

  sequence s_wrap_only;
    wrap_event && !wr_reload;
  endsequence

  a_mode_reset_value: assert property (
    @(posedge ref_clk) $past(srst) |-> timer_mode_ctrl_reg == MODE_RESET)
    else $error("Mode register not at reset value after reset.");

  a_reserved_bits_one: assert property (
    @(posedge ref_clk) disable iff (srst)
    (timer_mode_ctrl_reg & MODE_RSVD_ONES) == MODE_RSVD_ONES)
    else $error("Reserved mode bits are not one.");

  a_count_up_step: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_plain_up |=> timer_count_value_reg == $past(timer_count_value_reg) + 8'h01)
    else $error("Up count did not step by one.");

  a_count_down_step: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_plain_down |=> timer_count_value_reg == $past(timer_count_value_reg) - 8'h01)
    else $error("Down count did not step by one.");

  a_interval_wrap_value: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_wrap_only and !reload_mode_select
      |=> timer_count_value_reg == ($past(count_down) ? CNT_MAX : CNT_MIN))
    else $error("Interval wrap value wrong.");

  a_auto_reload_load: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_wrap_only and reload_mode_select
      |=> timer_count_value_reg == $past(timer_reload_value_reg))
    else $error("Auto-reload did not load the reload value.");

  a_write_loads_count: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_reload_write |=> timer_count_value_reg == $past(wbyte)
                       && timer_reload_value_reg == $past(wbyte))
    else $error("Reload write did not load counter and reload value.");

  a_flag_on_wrap: assert property (
    @(posedge ref_clk) disable iff (srst)
    wrap_event |=> overflow_request_flag_reg)
    else $error("Wrap did not set the request flag.");

  a_irq_follows_gate: assert property (
    @(posedge ref_clk) disable iff (srst)
    overflow_request_flag_reg && overflow_irq_enable_reg |=> irq_out)
    else $error("Interrupt not raised for enabled flag.");

  a_pin_sets_direction: assert property (
    @(posedge ref_clk) disable iff (srst)
    direction_source_select |-> count_down == $past(direction_pin, 2))
    else $error("Direction does not follow the direction pin.");

  a_ext_edge_only: assert property (
    @(posedge ref_clk) disable iff (srst)
    ext_sel && count_tick |-> $past(ev_sync_reg[1]) != ev_sync_reg[1]
                              && ev_sync_reg[1] == event_edge_polarity_reg)
    else $error("External count without the chosen edge.");

  // The fastest tap is the one short tests lean on, so its exact period is checked.
  // The slowest tap would need thousands of unrolled cycles and is left to the bench.
  localparam int FAST_TAP = NUM_TAPS - 1;

  // First cycle of an access phase, before the one wait state has passed.
  sequence s_access_first;
    psel && penable && !pready;
  endsequence

  a_fast_tap_period: assert property (
    @(posedge ref_clk) disable iff (srst)
    tap_pulse[FAST_TAP] |=> (!tap_pulse[FAST_TAP]) [*7] ##1 tap_pulse[FAST_TAP])
    else $error("Fastest prescaler tap is not one pulse in eight cycles.");

  a_count_holds_idle: assert property (
    @(posedge ref_clk) disable iff (srst)
    !count_tick && !wr_reload |=> $stable(timer_count_value_reg))
    else $error("Counter moved without a count pulse or a reload write.");

  a_reload_holds: assert property (
    @(posedge ref_clk) disable iff (srst)
    !wr_reload |=> $stable(timer_reload_value_reg))
    else $error("Reload value changed without a write.");

  a_flag_sw_clear: assert property (
    @(posedge ref_clk) disable iff (srst)
    wr_req && !wbyte[FLAG_BIT] && !wrap_event |=> !overflow_request_flag_reg)
    else $error("Request flag did not clear on a zero write.");

  a_irq_masked: assert property (
    @(posedge ref_clk) disable iff (srst)
    !(overflow_request_flag_reg && overflow_irq_enable_reg) |=> !irq_out)
    else $error("Interrupt raised without an enabled request.");

  a_ready_one_wait: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_access_first |=> pready)
    else $error("Bus answer did not come after one wait state.");

  a_ready_pulse: assert property (
    @(posedge ref_clk) disable iff (srst)
    pready |=> !pready)
    else $error("Bus ready stood longer than one cycle.");

  a_read_count_word: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_access_first ##0 (!pwrite && hit_count)
      |=> prdata[7:0] == $past(timer_count_value_reg) && prdata[DATA_W-1:8] == '0)
    else $error("Counter read returned the wrong word.");

  a_read_mode_word: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_access_first ##0 (!pwrite && hit_mode)
      |=> (prdata[7:0] & MODE_RSVD_ONES) == MODE_RSVD_ONES)
    else $error("Mode read did not show the reserved bits as one.");

  a_write_reads_zero: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_access_first ##0 pwrite |=> prdata == '0)
    else $error("Write access returned non-zero read data.");

  // A polarity write in the same cycle could turn the next level change into a new edge.
  a_edge_one_cycle: assert property (
    @(posedge ref_clk) disable iff (srst)
    ev_edge && !wr_edge |=> !ev_edge)
    else $error("Event edge enable lasted more than one cycle.");

endmodule
`default_nettype wire

/* dv/pin_driver_model.sv */
// Purpose: Far-side model of the event input pin and the direction pin.
// Assumes: Requests from the bench change just after a rising edge of ref_clk.
// Notes:   Pins sit low until routed, as a port pin still in general use would.
`timescale 1ns/10ps
`default_nettype none
module pin_driver_model (
  input  wire logic ref_clk,
  input  wire logic routed,
  input  wire logic ev_req,
  input  wire logic dir_req,
  output logic      event_input_pin,
  output logic      direction_pin
);
  // Levels leave a flop so they never move in the sampling step of the timer.
  always_ff @(posedge ref_clk) begin
    event_input_pin <= routed & ev_req;
    direction_pin   <= routed & dir_req;
  end
endmodule
`default_nettype wire

/* dv/updown_reload_timer_tb_top.sv */
// Purpose: Self-checking bench for the up/down reload timer over APB.
// Assumes: One wait state per access; event pin counted four edges after it moves.
// Notes:   Counter tests use the event pin, apart from the two prescaler tap runs, so every expected value is exact.
`timescale 1ns/10ps
`default_nettype none
module updown_reload_timer_tb_top;
  import updown_timer_pkg::*;
  logic              ref_clk, srst, psel, penable, pwrite, routed, ev_req, dir_req;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic              pready, pslverr, event_input_pin, direction_pin, irq_out;
  logic [DATA_W:0]   note_q[$];
  int                n_fail, n_tests;

  updown_reload_timer uut (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_input_pin(event_input_pin), .direction_pin(direction_pin),
    .irq_out(irq_out));
  pin_driver_model pins (.ref_clk(ref_clk), .routed(routed), .ev_req(ev_req),
    .dir_req(dir_req), .event_input_pin(event_input_pin), .direction_pin(direction_pin));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check_val(input logic [DATA_W:0] got, input logic [DATA_W:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_irq(input logic exp);
    n_tests++;
    if (irq_out !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, irq_out, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Each access notes its expected {pslverr, prdata}; the monitor below compares.
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                     input logic [DATA_W:0] exp);
    int k;
    k = 0;
    note_q.push_back(exp);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h00_0000, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, {1'b0, 32'h0000_0000});
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] v);
    apb(1'b0, idx, 8'h00, {1'b0, 24'h00_0000, v});
  endtask

  // Six cycles cover the two sync flops, the edge flop and the counter update.
  task automatic ev(input logic level);
    ev_req <= level;
    cycles(6);
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      ev(1'b1);
      ev(1'b0);
    end
  endtask

  always @(posedge ref_clk) begin
    if (psel && penable && pready) begin
      if (note_q.size() == 0) begin
        check_val({pslverr, prdata}, {1'b1, 32'hFFFF_FFFF});
      end else begin
        check_val({pslverr, prdata}, note_q.pop_front());
      end
    end
  end

  initial begin
    logic [7:0] v;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    routed = 1'b0;
    ev_req = 1'b0;
    dir_req = 1'b0;
    n_fail = 0;
    n_tests = 0;
    void'($urandom(7));
    cycles(8);
    srst <= 1'b0;
    rd(MODE_IDX, 8'h18);
    rd(COUNT_IDX, 8'h00);
    // The slowest tap fires once after 8192 cycles, so one step is expected here.
    cycles(8300);
    rd(COUNT_IDX, 8'h01);
    for (int cs = 0; cs < 8; cs++) begin
      v = {3'($urandom), 2'($urandom), 3'(cs)};
      wr(MODE_IDX, v);
      rd(MODE_IDX, (v & MODE_WR_MASK) | MODE_RSVD_ONES);
    end
    routed <= 1'b1;
    wr(EDGE_SEL_IDX, 8'h01);
    rd(EDGE_SEL_IDX, 8'h01);
    wr(MODE_IDX, 8'h07);
    v = 8'($urandom);
    wr(COUNT_IDX, v);
    rd(COUNT_IDX, v);
    wr(IRQ_REQ_IDX, 8'h00);
    wr(COUNT_IDX, 8'hFE);
    pulses(1);
    rd(COUNT_IDX, 8'hFF);
    rd(IRQ_REQ_IDX, 8'h00);
    pulses(1);
    rd(COUNT_IDX, 8'h00);
    rd(IRQ_REQ_IDX, 8'h01);
    check_irq(1'b0);
    wr(IRQ_EN_IDX, 8'h01);
    cycles(2);
    check_irq(1'b1);
    wr(IRQ_REQ_IDX, 8'h00);
    cycles(2);
    check_irq(1'b0);
    wr(MODE_IDX, 8'h27);
    wr(COUNT_IDX, 8'h00);
    pulses(1);
    rd(COUNT_IDX, 8'hFF);
    rd(IRQ_REQ_IDX, 8'h01);
    wr(MODE_IDX, 8'h87);
    wr(COUNT_IDX, 8'hFE);
    pulses(2);
    rd(COUNT_IDX, 8'hFE);
    dir_req <= 1'b1;
    wr(MODE_IDX, 8'h47);
    wr(COUNT_IDX, 8'h10);
    pulses(1);
    rd(COUNT_IDX, 8'h0F);
    dir_req <= 1'b0;
    wr(MODE_IDX, 8'h67);
    pulses(2);
    rd(COUNT_IDX, 8'h11);
    // Any 64 cycles hold exactly eight pulses of the fastest tap, whatever its phase.
    wr(MODE_IDX, 8'h06);
    wr(COUNT_IDX, 8'h40);
    cycles(62);
    rd(COUNT_IDX, 8'h48);
    apb(1'b1, 16'h0000, 8'h55, {1'b1, 32'h0000_0000});
    apb(1'b0, 16'h0000, 8'h00, {1'b1, 32'h0000_0000});
    // A second reset mid-run must leave a zero reload value behind.
    srst <= 1'b1;
    cycles(8);
    srst <= 1'b0;
    rd(MODE_IDX, 8'h18);
    wr(MODE_IDX, 8'hA7);
    ev(1'b1);
    rd(IRQ_REQ_IDX, 8'h00);
    ev(1'b0);
    rd(COUNT_IDX, 8'h00);
    rd(IRQ_REQ_IDX, 8'h01);
    tally_and_finish();
  end
endmodule
`default_nettype wire
